// ### logic/vsic_pkg.sv
/*
 * Constants shared by the video input control block of a serializer.
 * Assumes one pixel clock; all pins are synchronous to it.
 */
// Operation
// - With filtering off, control transitions pass at any pulse width.
// - Inputs latch on rising edge when edge select is 1, else falling.
// - Power-down input high means normal capture and serialization.
// - Power-down input low stops the loop and parks the drivers.
// - Two-bit mode picks partner generation and filter on or off.
// - Swing select 1 gives about 840 mVp-p, 0 about 560 mVp-p.
// - De-emphasis stays off while its pin floats; grounded enables it.
// - Self-test mode follows the self-test enable input.
// - Bus target address derives from the address select setting.
// - SCL is input only; SDA is open drain, never driven high.
`default_nettype none
package vsic_pkg;
   localparam int COLOR_W = 24;
   localparam int CTRL_W = 3;
   localparam int PIX_W = COLOR_W + CTRL_W;
   localparam int FIFO_DEPTH = 32;
   // Pixel word: {frame_sync, line_sync, pixel_valid, color}
   localparam int POS_VALID = 24;
   localparam int POS_LINE = 25;
   localparam int POS_FRAME = 26;
   localparam logic [1:0] MODE_CUR_DIRECT = 2'h0;
   localparam logic [1:0] MODE_CUR_FILTER = 2'h1;
   localparam logic [1:0] MODE_OLDER = 2'h2;
   localparam logic [1:0] MODE_OLDEST = 2'h3;
   localparam logic [1:0] FILT_MIN_PULSE = 2'h3;
   localparam int CTRL_WINDOW_CLKS = 130;
   localparam int SWING_LARGE_MV = 840;
   localparam int SWING_SMALL_MV = 560;
   // Defaults while powered down
   localparam logic RST_EDGE_SEL = 1'h0;
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic RST_SWING = 1'h0;
   localparam logic RST_DEEMPH = 1'h0;
   localparam logic RST_SELFTEST = 1'h0;
   // Bus address base; value is arbitrary
   localparam logic [6:0] BUS_ADDR_BASE = 7'h10;
   localparam logic [6:0] RST_BUS_ADDR = 7'h00;
   localparam int CLK_PERIOD_PS = 5000;
endpackage
`default_nettype wire

// ### logic/vsic_fifo.sv
/*
 * Pixel FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module vsic_fifo
   import vsic_pkg::*;
#(
   parameter int WIDTH = PIX_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } vsic_fifo_st_t;

   vsic_fifo_st_t st_ff;
   vsic_fifo_st_t nxt_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;
   logic full;
   logic empty;

   assign empty = st_ff.wr == st_ff.rd;
   assign full = (st_ff.wr[AW] != st_ff.rd[AW]) &&
                 (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]);
   assign in_ready = !full && !flush;
   assign out_valid = !empty && !flush;
   assign out_data = mem[st_ff.rd[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (flush) begin
         nxt_st.wr = '0;
         nxt_st.rd = '0;
      end else begin
         if (push) nxt_st.wr = st_ff.wr + 1'h1;
         if (pop) nxt_st.rd = st_ff.rd + 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   // Storage carries no reset; only pointers need a defined value
   always_ff @(posedge clk) begin
      if (push) mem[st_ff.wr[AW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

// ### logic/vsic_input_ctrl.sv
/*
 * Parallel video input capture and pin configuration of a serializer.
 * Assumes all pins synchronous to clk (the pixel clock); the serial
 * stage drains out_data and may stall it through out_ready.
 */
`timescale 1ns/1ps
`default_nettype none
module vsic_input_ctrl
   import vsic_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic power_down_n,
   input wire logic [COLOR_W-1:0] color_in,
   input wire logic pixel_valid_in,
   input wire logic line_sync_in,
   input wire logic frame_sync_in,
   input wire logic latch_edge_select,
   input wire logic [1:0] link_mode_select,
   input wire logic output_swing_select,
   input wire logic deemphasis_control_open,
   input wire logic link_selftest_enable,
   input wire logic [2:0] bus_address_select,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_pull_req,
   output logic sda_out,
   output logic sda_oe,
   output logic bus_scl_ff,
   output logic bus_sda_ff,
   output logic [6:0] bus_target_addr,
   output logic pll_enable,
   output logic driver_park,
   output logic filter_active,
   output logic [1:0] partner_gen,
   output logic swing_large,
   output logic deemph_enable,
   output logic selftest_active,
   output logic capture_overflow,
   output logic [PIX_W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   // ************************************************
   // State
   // ************************************************
   typedef enum logic {ST_DOWN, ST_RUN} vsic_mode_t;

   typedef struct packed {
      vsic_mode_t mode;
      logic edge_sel;
      logic [1:0] link_mode;
      logic swing;
      logic deemph;
      logic selftest;
      logic [6:0] addr;
      logic scl;
      logic sda;
      logic [PIX_W-1:0] dly;
      logic [CTRL_W-1:0] filt;
      logic [CTRL_W-1:0][1:0] cnt;
      logic [PIX_W-1:0] cap;
      logic cap_valid;
      logic [COLOR_W-1:0] pat;
      logic overflow;
   } vsic_state_t;

   vsic_state_t st_ff;
   vsic_state_t nxt_st;
   logic [PIX_W-1:0] raw;
   logic [PIX_W-1:0] sample;
   logic fifo_in_ready;
   logic running;

   function automatic logic [6:0] addr_of(input logic [2:0] sel);
      return BUS_ADDR_BASE + {3'h0, sel, 1'h0};
   endfunction

   assign raw = {frame_sync_in, line_sync_in, pixel_valid_in, color_in};
   assign running = st_ff.mode == ST_RUN;
   // edge select
   // Falling-edge latch is carried by one extra register stage, since
   // the block has one clock edge to work with.
   assign sample = st_ff.edge_sel ? raw : st_ff.dly;

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.scl = scl_in;
      nxt_st.sda = sda_in;
      nxt_st.dly = raw;
      nxt_st.cap_valid = 1'h0;
      if (!power_down_n) begin
         nxt_st.mode = ST_DOWN;
         nxt_st.edge_sel = RST_EDGE_SEL;
         nxt_st.link_mode = RST_MODE;
         nxt_st.swing = RST_SWING;
         nxt_st.deemph = RST_DEEMPH;
         nxt_st.selftest = RST_SELFTEST;
         nxt_st.addr = RST_BUS_ADDR;
         nxt_st.filt = '0;
         nxt_st.cnt = '0;
         nxt_st.pat = '0;
         nxt_st.overflow = 1'h0;
      end else begin
         // normal operation, pins followed each cycle
         nxt_st.mode = ST_RUN;
         nxt_st.edge_sel = latch_edge_select;
         nxt_st.link_mode = link_mode_select;
         nxt_st.swing = output_swing_select;
         nxt_st.deemph = !deemphasis_control_open;
         nxt_st.selftest = link_selftest_enable;
         nxt_st.addr = addr_of(bus_address_select);
         if (running) begin
            for (int i = 0; i < CTRL_W; i++) begin
               if (st_ff.link_mode != MODE_CUR_FILTER) begin
                  nxt_st.filt[i] = sample[COLOR_W+i];
                  nxt_st.cnt[i] = 2'h0;
               end else if (sample[COLOR_W+i] == st_ff.filt[i]) begin
                  nxt_st.cnt[i] = 2'h0;
               end else if (st_ff.cnt[i] == FILT_MIN_PULSE - 2'h1) begin
                  nxt_st.filt[i] = sample[COLOR_W+i];
                  nxt_st.cnt[i] = 2'h0;
               end else begin
                  nxt_st.cnt[i] = st_ff.cnt[i] + 2'h1;
               end
            end
            // Colour is aligned to the unfiltered control timing; the
            // filter only delays control edges, never colour.
            if (st_ff.selftest) begin
               nxt_st.cap = {3'h1, st_ff.pat};
               nxt_st.pat = st_ff.pat + 24'h000001;
            end else begin
               nxt_st.cap = {nxt_st.filt, sample[COLOR_W-1:0]};
            end
            nxt_st.cap_valid = 1'h1;
            // Video cannot be held off: a stalled FIFO loses the word
            if (st_ff.cap_valid && !fifo_in_ready) nxt_st.overflow = 1'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.mode <= ST_DOWN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign pll_enable = running;
   assign driver_park = !running;
   assign filter_active = st_ff.link_mode == MODE_CUR_FILTER;
   assign partner_gen = st_ff.link_mode;
   assign swing_large = st_ff.swing;
   assign deemph_enable = st_ff.deemph;
   assign selftest_active = st_ff.selftest;
   assign bus_target_addr = st_ff.addr;
   assign bus_scl_ff = st_ff.scl;
   assign bus_sda_ff = st_ff.sda;
   assign capture_overflow = st_ff.overflow;
   // open drain, only ever pulls low
   assign sda_out = 1'h0;
   assign sda_oe = sda_pull_req && running;

   vsic_fifo #(
      .WIDTH(PIX_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .flush(!running),
      .in_valid(st_ff.cap_valid),
      .in_ready(fifo_in_ready),
      .in_data(st_ff.cap),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [CTRL_W-1:0] smp_ctrl;
   assign smp_ctrl = sample[POS_FRAME:POS_VALID];

   sequence s_low_pd;
      !power_down_n;
   endsequence
   sequence s_parked;
      !pll_enable && driver_park;
   endsequence

   property p_pd_park;
      s_low_pd |=> s_parked;
   endproperty
   a_pd_park: assert property (p_pd_park)
      else $error("power-down did not park the link");

   property p_run;
      power_down_n |=> pll_enable && !driver_park;
   endproperty
   a_run: assert property (p_run)
      else $error("link not running with power-down released");

   property p_pd_defaults;
      !power_down_n |=> partner_gen == RST_MODE && !selftest_active
         && !swing_large && !deemph_enable;
   endproperty
   a_pd_defaults: assert property (p_pd_defaults)
      else $error("configuration not at defaults in power-down");

   property p_direct;
      running && power_down_n && partner_gen == MODE_CUR_DIRECT
         |=> st_ff.filt == $past(smp_ctrl);
   endproperty
   a_direct: assert property (p_direct)
      else $error("unfiltered control did not follow input");

   sequence s_held3;
      (running && power_down_n && filter_active
         && smp_ctrl[0] != st_ff.filt[0]) [*3];
   endsequence
   property p_filter_pass;
      s_held3 |=> st_ff.filt[0] == $past(smp_ctrl[0]);
   endproperty
   a_filter_pass: assert property (p_filter_pass)
      else $error("held valid pulse not passed by filter");

   property p_filter_block;
      running && power_down_n && filter_active && st_ff.cnt[1] == 2'h0
         && smp_ctrl[1] != st_ff.filt[1]
         |=> st_ff.filt[1] == $past(st_ff.filt[1]);
   endproperty
   a_filter_block: assert property (p_filter_block)
      else $error("one-clock line sync pulse passed the filter");

   property p_rise_edge;
      running && power_down_n && st_ff.edge_sel && !st_ff.selftest
         && partner_gen != MODE_CUR_FILTER
         |=> st_ff.cap == $past(raw);
   endproperty
   a_rise_edge: assert property (p_rise_edge)
      else $error("rising-edge capture did not take the pins");

   property p_mode;
      power_down_n |=> partner_gen == $past(link_mode_select)
         && filter_active == ($past(link_mode_select) == MODE_CUR_FILTER);
   endproperty
   a_mode: assert property (p_mode)
      else $error("link mode does not follow select");

   property p_swing;
      power_down_n |=> swing_large == $past(output_swing_select);
   endproperty
   a_swing: assert property (p_swing)
      else $error("swing does not follow select");

   property p_deemph;
      power_down_n && deemphasis_control_open |=> !deemph_enable;
   endproperty
   a_deemph: assert property (p_deemph)
      else $error("de-emphasis on with floating pin");

   property p_selftest;
      power_down_n |=> selftest_active == $past(link_selftest_enable);
   endproperty
   a_selftest: assert property (p_selftest)
      else $error("self-test mode does not follow enable");

   property p_addr;
      power_down_n |=> bus_target_addr
         == BUS_ADDR_BASE + {3'h0, $past(bus_address_select), 1'h0};
   endproperty
   a_addr: assert property (p_addr)
      else $error("bus address does not match select");

   property p_sda;
      sda_oe |-> !sda_out;
   endproperty
   a_sda: assert property (p_sda)
      else $error("SDA driven high");
endmodule
`default_nettype wire

// ### tb/vsic_src_model.sv
/*
 * Video source model: a free-running colour count, with valid and the
 * syncs derived from it. Assumes the capture block's clk and rst.
 */
`timescale 1ns/1ps
`default_nettype none
module vsic_src_model
   import vsic_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic glitch,
   output logic [COLOR_W-1:0] color_in,
   output logic pixel_valid_in,
   output logic line_sync_in,
   output logic frame_sync_in
);
   logic [COLOR_W-1:0] cnt_ff;
   logic [7:0] ph;
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 24'h1;
      end
   end
   assign ph = 8'(cnt_ff % 24'h8c);
   assign color_in = cnt_ff;
   assign pixel_valid_in = ph < 8'h64;
   // ten clock pulse
   // The glitch is a one clock pulse that breaks on purpose
   assign line_sync_in = glitch ? ph == 8'h3c : (ph >= 8'h78 && ph < 8'h82);
   assign frame_sync_in = (cnt_ff / 24'h8c) % 24'h2 == 24'h1;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench of the video input control block.
 * Assumes the source model beside it and a serial side held ready except in the overflow test.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vsic_pkg::*;
   logic clk, rst, pdn, edge_sel, swing, dopen, bist, scl, sda, pull;
   logic glitch, out_ready, pv, ls, fs;
   logic sda_out, sda_oe, scl_ff, sda_ff, pll, park, filt, swl, dee, st;
   logic ovf, ov;
   logic [1:0] mode, gen;
   logic [2:0] addr;
   logic [6:0] badr;
   logic [COLOR_W-1:0] color;
   logic [PIX_W-1:0] od;
   int bad_count, tests_run;
   // Rows: {power_down_n, mode, swing, pin open, selftest, address code}
   logic [8:0] cin [6] = '{9'h130, 9'h143, 9'h1bf, 9'h1c5, 9'h06f, 9'h16f};
   // Rows: {pll, filter, partner, swing, deemph, selftest, address}
   logic [13:0] cexp [6] = '{14'h2210, 14'h3516, 14'h2a9e, 14'h2d1a,
      14'h0000, 14'h379e};

   vsic_src_model u_src (.clk(clk), .rst(rst), .glitch(glitch),
      .color_in(color), .pixel_valid_in(pv), .line_sync_in(ls),
      .frame_sync_in(fs));
   vsic_input_ctrl u_dut (.clk(clk), .rst(rst), .power_down_n(pdn),
      .color_in(color), .pixel_valid_in(pv), .line_sync_in(ls),
      .frame_sync_in(fs), .latch_edge_select(edge_sel),
      .link_mode_select(mode), .output_swing_select(swing),
      .deemphasis_control_open(dopen), .link_selftest_enable(bist),
      .bus_address_select(addr), .scl_in(scl), .sda_in(sda),
      .sda_pull_req(pull), .sda_out(sda_out), .sda_oe(sda_oe),
      .bus_scl_ff(scl_ff), .bus_sda_ff(sda_ff), .bus_target_addr(badr),
      .pll_enable(pll), .driver_park(park), .filter_active(filt),
      .partner_gen(gen), .swing_large(swl), .deemph_enable(dee),
      .selftest_active(st), .capture_overflow(ovf), .out_data(od),
      .out_valid(ov), .out_ready(out_ready));

   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic end_sim;
      if (bad_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Expected {frame, line, valid} of a word, worked out from its colour
   function automatic logic [2:0] exp_ctrl(input logic [COLOR_W-1:0] c);
      logic [7:0] ph;
      ph = 8'(c % 24'h8c);
      exp_ctrl = {(c / 24'h8c) % 24'h2 == 24'h1,
         glitch ? ph == 8'h3c : (ph >= 8'h78 && ph < 8'h82), ph < 8'h64};
   endfunction

   // Power-down flushes the FIFO, so each stream starts clean
   task automatic restart(input logic e, input logic [1:0] m,
         input logic b, input logic g);
      @(posedge clk);
      pdn <= 1'h0;
      edge_sel <= e;
      mode <= m;
      bist <= b;
      glitch <= g;
      repeat (3) @(posedge clk);
      pdn <= 1'h1;
   endtask

   // Kind 0 exact control bits, 1 filtered, 2 self-test pattern
   task automatic stream(input int n, input int kind);
      logic [COLOR_W-1:0] prev;
      logic seen;
      int lines;
      seen = 1'h0;
      lines = 0;
      prev = '0;
      repeat (n) begin
         @(negedge clk);
         if (ov === 1'b1) begin
            if (seen) cmp(od[COLOR_W-1:0], prev + 24'h1);
            if (kind == 0) cmp(od[26:24], exp_ctrl(od[COLOR_W-1:0]));
            if (kind == 2) cmp(od[26:24], 3'h1);
            lines += od[POS_LINE];
            prev = od[COLOR_W-1:0];
            seen = 1'h1;
         end
      end
      cmp(seen, 1'h1);
      if (kind == 1) cmp(lines > 0, !glitch);
   endtask

   initial begin
      #50000;
      bad_count++;
      end_sim();
   end

   initial begin
      {rst, pdn, edge_sel, dopen, scl, sda, pull, out_ready} = 8'hff;
      {mode, swing, bist, addr, glitch} = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (9) @(posedge clk);
      #1;
      cmp({pll, park, ov, ovf, badr}, {4'h4, 7'h00});
      @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         {pdn, mode, swing, dopen, bist, addr} <= cin[i];
         scl <= i[0];
         sda <= ~i[0];
         pull <= ~i[1];
         repeat (3) @(posedge clk);
         #1;
         cmp({pll, filt, gen, swl, dee, st, badr}, cexp[i]);
         cmp({park, sda_oe, sda_out, scl_ff, sda_ff},
            {~cexp[i][13], cexp[i][13] & ~i[1], 1'h0, i[0], ~i[0]});
      end
      @(posedge clk);
      {swing, dopen, addr} <= '1;
      restart(1'h1, MODE_CUR_DIRECT, 1'h0, 1'h0);
      stream(300, 0);
      restart(1'h0, MODE_CUR_DIRECT, 1'h0, 1'h1);
      stream(300, 0);
      restart(1'h1, MODE_CUR_FILTER, 1'h0, 1'h1);
      stream(300, 1);
      restart(1'h1, MODE_CUR_FILTER, 1'h0, 1'h0);
      stream(300, 1);
      restart(1'h1, MODE_CUR_DIRECT, 1'h1, 1'h0);
      stream(100, 2);
      // The source cannot stall, so a blocked FIFO must drop and flag
      restart(1'h1, MODE_CUR_DIRECT, 1'h0, 1'h0);
      @(posedge clk);
      out_ready <= 1'h0;
      repeat (40) @(posedge clk);
      #1;
      cmp({ov, ovf}, 2'h3);
      @(posedge clk);
      out_ready <= 1'h1;
      repeat (10) @(posedge clk);
      #1;
      cmp(ovf, 1'h1);
      @(posedge clk);
      pdn <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      cmp({ov, ovf, pll, park, sda_oe}, 5'h02);
      end_sim();
   end
endmodule
`default_nettype wire
